// >>> testbench/dpsb_dev_model.sv
// One port of the dual-port RAM with its eight token latches.
// Assumes pins sampled on MCLK; far port driven by bench through tok_write.
`timescale 1ns/100ps
module dpsb_dev_model import dpsb_pkg::*; (
    input  wire logic                   clk,
    input  wire logic                   array_sel_n,
    input  wire logic                   token_select_n,
    input  wire logic                   out_drive_n,
    input  wire logic                   write_n,
    input  wire logic [DPSB_ADDR_W-1:0] addr,
    input  wire logic [DPSB_DATA_W-1:0] dq_o,
    input  wire logic                   busy_hold_n,
    output logic      [DPSB_DATA_W-1:0] dq_i,
    output logic                        busy_n
);
    // ==========================================
    // Storage; request latches start pending, as after power-up
    logic [DPSB_DATA_W-1:0] mem [0:8191];
    logic [7:0]             req [2] = '{8'h00, 8'h00};
    logic [7:0]             own [2] = '{8'h00, 8'h00};
    logic                   rd_q    = 1'b0;
    logic                   wr_q    = 1'b1;
    int                     tok_wr_n = 0;
    logic [DPSB_DATA_W-1:0] out_r   = 9'h000;
    wire                    tok_rd  = !token_select_n && !out_drive_n;
    wire                    arr_rd  = !array_sel_n && !out_drive_n;

    // Side 0 is our port, side 1 the far port
    task automatic tok_write(input int s, input int i, input logic v);
        req[s][i] = v;
        if (!v && !own[1-s][i]) own[s][i] = 1'b1;
        if (v) begin
            own[s][i] = 1'b0;
            if (!req[1-s][i]) own[1-s][i] = 1'b1;
        end
    endtask

    // ==========================================
    always @(posedge clk) begin
        rd_q <= tok_rd;
        wr_q <= write_n;
        if (!token_select_n && !write_n && wr_q) tok_wr_n <= tok_wr_n + 1;
        if (!token_select_n && !write_n) tok_write(0, addr[2:0], dq_o[0]);
        if (!array_sel_n && !write_n && busy_n) mem[addr] <= dq_o;
        if (tok_rd && !rd_q) out_r <= {9{!own[0][addr[2:0]]}};
        if (arr_rd) out_r <= mem[addr];
    end

    // Released bus shows inverse of last value; standby when both selects high
    assign dq_i   = (tok_rd || arr_rd) ? out_r : ~out_r;
    assign busy_n = busy_hold_n;
endmodule // dpsb_dev_model

// >>> testbench/dpsb_host_tb.sv
// Self-checking bench for the token host controller.
// Assumes the device model stands on the pins; far port poked directly.
`timescale 1ns/100ps
module dpsb_host_tb;
    import dpsb_pkg::*;
    logic MCLK, SYS_RST, REQ_VALID, REQ_TOKEN, REQ_READY, RSP_VALID, RSP_GRANTED, INIT_DONE;
    logic [1:0]  REQ_OP;
    logic [12:0] REQ_ADDR, ADDR;
    logic [8:0]  REQ_WDATA, RSP_RDATA, DQ_O, DQ_I;
    logic ARRAY_SEL_N, TOKEN_SELECT_N, OUT_DRIVE_N, WRITE_N, DQ_OE, BUSY_N, busy_hold_n;
    int n_tests = 0;
    int fail_count = 0;

    dpsb_host u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
        .REQ_TOKEN(REQ_TOKEN), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY),
        .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .RSP_GRANTED(RSP_GRANTED), .INIT_DONE(INIT_DONE),
        .ARRAY_SEL_N(ARRAY_SEL_N), .TOKEN_SELECT_N(TOKEN_SELECT_N), .OUT_DRIVE_N(OUT_DRIVE_N),
        .WRITE_N(WRITE_N), .ADDR(ADDR), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(DQ_I), .BUSY_N(BUSY_N));
    dpsb_dev_model u_model (.clk(MCLK), .array_sel_n(ARRAY_SEL_N), .token_select_n(TOKEN_SELECT_N),
        .out_drive_n(OUT_DRIVE_N), .write_n(WRITE_N), .addr(ADDR), .dq_o(DQ_O),
        .busy_hold_n(busy_hold_n), .dq_i(DQ_I), .busy_n(BUSY_N));

    // ==========================================
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("tests=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hold request until taken, then wait for the response pulse
    task automatic do_req(input logic [1:0] op, input logic tok, input logic [12:0] a, input logic [8:0] d);
        int k;
        k = 0;
        REQ_VALID = 1'b1;
        REQ_OP = op;
        REQ_TOKEN = tok;
        REQ_ADDR = a;
        REQ_WDATA = d;
        while (REQ_READY !== 1'b1 && k < 500) begin
            @(posedge MCLK);
            #1 k++;
        end
        @(posedge MCLK);
        #1 REQ_VALID = 1'b0;
        while (RSP_VALID !== 1'b1 && k < 500) begin
            @(posedge MCLK);
            #1 k++;
        end
        check(k < 500, 1'b1);
    endtask

    // ==========================================
    task automatic t_init;
        int k;
        for (k = 0; k < 500 && INIT_DONE !== 1'b1; k++) @(posedge MCLK);
        #1 check(INIT_DONE, 1'b1);
        check(u_model.req[0], 8'hff);
        for (int i = 0; i < 8; i++) u_model.tok_write(1, i, 1'b1);
        check(u_model.own[0] | u_model.own[1], 8'h00);
        $display("test init done");
    endtask

    task automatic t_contend;
        int n;
        do_req(DPSB_OP_CLAIM, 1'b1, 13'h1ffd, 9'h000);
        check(RSP_GRANTED, 1'b1);
        check(RSP_RDATA, 9'h000);
        u_model.tok_write(1, 5, 1'b0);
        check(u_model.own[1][5], 1'b0);
        do_req(DPSB_OP_RELEASE, 1'b1, 13'h0005, 9'h000);
        check(u_model.own[1][5], 1'b1);
        do_req(DPSB_OP_CLAIM, 1'b1, 13'h0005, 9'h000);
        check(RSP_GRANTED, 1'b0);
        check(RSP_RDATA, 9'h1ff);
        // Far side lets go: our latched request takes over; retry must only read
        n = u_model.tok_wr_n;
        u_model.tok_write(1, 5, 1'b1);
        check(u_model.own[0][5], 1'b1);
        do_req(DPSB_OP_CLAIM, 1'b1, 13'h0005, 9'h000);
        check(RSP_GRANTED, 1'b1);
        check(u_model.tok_wr_n, n);
        do_req(DPSB_OP_RELEASE, 1'b1, 13'h0005, 9'h000);
        check(u_model.req[0][5], 1'b1);
        u_model.tok_write(1, 5, 1'b1);
        $display("test contend done");
    endtask

    task automatic t_bitonly;
        do_req(DPSB_OP_WRITE, 1'b1, 13'h0f02, 9'h1fe);
        check(u_model.own[0][2], 1'b1);
        do_req(DPSB_OP_READ, 1'b1, 13'h0002, 9'h000);
        check(RSP_RDATA, 9'h000);
        do_req(DPSB_OP_WRITE, 1'b1, 13'h0002, 9'h001);
        do_req(DPSB_OP_READ, 1'b1, 13'h0002, 9'h000);
        check(RSP_RDATA, 9'h1ff);
        $display("test bitonly done");
    endtask

    task automatic t_array;
        busy_hold_n = 1'b0;
        fork
            do_req(DPSB_OP_WRITE, 1'b0, 13'h0123, 9'h155);
            begin
                repeat (30) @(posedge MCLK);
                #1 check(WRITE_N, 1'b1);
                check(ARRAY_SEL_N, 1'b0);
                check(DQ_OE, 1'b1);
                check(REQ_READY, 1'b0);
                busy_hold_n = 1'b1;
            end
        join
        check(u_model.mem[13'h0123], 9'h155);
        do_req(DPSB_OP_READ, 1'b0, 13'h0123, 9'h000);
        check(RSP_RDATA, 9'h155);
        $display("test array done");
    endtask

    // ==========================================
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end

    initial begin
        SYS_RST = 1'b1;
        REQ_VALID = 1'b0;
        REQ_OP = 2'h0;
        REQ_TOKEN = 1'b0;
        REQ_ADDR = 13'h0000;
        REQ_WDATA = 9'h000;
        busy_hold_n = 1'b1;
        repeat (3) @(posedge MCLK);
        #1 SYS_RST = 1'b0;
        t_init;
        t_contend;
        t_bitonly;
        t_array;
        summarize;
    end

    // About 290 cycles expected; allow about seventy times that
    initial begin
        #160000;
        fail_count++;
        summarize;
    end
endmodule // dpsb_host_tb

// >>> verilog/dpsb_cycle.sv
// Single pin-cycle sequencer: setup, strobe pulse, recovery.
// Assumes the caller holds its request steady until done.
`timescale 1ns/100ps
module dpsb_cycle import dpsb_pkg::*; #(
    parameter int SETUP_CYC = DPSB_SETUP_CYC,
    parameter int PULSE_CYC = DPSB_PULSE_CYC,
    parameter int REC_CYC   = DPSB_REC_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic busy_hold,
    output logic      strobe,
    output logic      phase_setup,
    output logic      done
);
    typedef enum logic [1:0] {DPSB_C_IDLE = 2'h0, DPSB_C_SET = 2'h1, DPSB_C_STB = 2'h3, DPSB_C_REC = 2'h2} dpsb_cph_t;
    dpsb_cph_t  ph_r, ph_nxt;
    logic [7:0] cnt_r, cnt_nxt;

    always_comb begin
        ph_nxt  = ph_r;
        cnt_nxt = cnt_r;
        case (ph_r)
            DPSB_C_IDLE: begin
                if (start) begin
                    ph_nxt  = DPSB_C_SET;
                    cnt_nxt = 8'h0;
                end
            end
            DPSB_C_SET: begin
                // Strobe waits until setup elapsed and the contention flag is high
                cnt_nxt = cnt_r + 8'h1;
                if (cnt_r >= 8'(SETUP_CYC - 1) && !busy_hold) begin
                    ph_nxt  = DPSB_C_STB;
                    cnt_nxt = 8'h0;
                end
            end
            DPSB_C_STB: begin
                cnt_nxt = cnt_r + 8'h1;
                if (cnt_r >= 8'(PULSE_CYC - 1)) begin
                    ph_nxt  = DPSB_C_REC;
                    cnt_nxt = 8'h0;
                end
            end
            DPSB_C_REC: begin
                cnt_nxt = cnt_r + 8'h1;
                if (cnt_r >= 8'(REC_CYC - 1)) begin
                    ph_nxt = DPSB_C_IDLE;
                end
            end
            default: ph_nxt = DPSB_C_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_r  <= DPSB_C_IDLE;
            cnt_r <= 8'h0;
        end else begin
            ph_r  <= ph_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign strobe      = (ph_r == DPSB_C_STB);
    assign phase_setup = (ph_r == DPSB_C_SET);
    assign done        = (ph_r == DPSB_C_REC) && (cnt_r >= 8'(REC_CYC - 1));

    a_strobe_after_setup: assert property (@(posedge clk) disable iff (rst)
        $rose(strobe) |-> $past(phase_setup) && !$past(busy_hold))
        else $error("strobe began without setup or while flag low");
endmodule // dpsb_cycle

// >>> verilog/dpsb_host.sv
// Host controller that drives one port of a dual-port RAM with tokens.
// Assumes the RAM pins are synchronous to MCLK; data bus is three signals.
`timescale 1ns/100ps
module dpsb_host import dpsb_pkg::*; #(
    parameter int ADDR_W = DPSB_ADDR_W,
    parameter int DATA_W = DPSB_DATA_W,
    parameter int NTOK   = DPSB_NTOK
) (
    input  wire logic              MCLK,
    input  wire logic              SYS_RST,
    // User command side
    input  wire logic              REQ_VALID,
    input  wire logic [1:0]        REQ_OP,
    input  wire logic              REQ_TOKEN,
    input  wire logic [ADDR_W-1:0] REQ_ADDR,
    input  wire logic [DATA_W-1:0] REQ_WDATA,
    output logic                   REQ_READY,
    output logic                   RSP_VALID,
    output logic [DATA_W-1:0]      RSP_RDATA,
    output logic                   RSP_GRANTED,
    output logic                   INIT_DONE,
    // Device pins
    output logic                   ARRAY_SEL_N,
    output logic                   TOKEN_SELECT_N,
    output logic                   OUT_DRIVE_N,
    output logic                   WRITE_N,
    output logic [ADDR_W-1:0]      ADDR,
    output logic [DATA_W-1:0]      DQ_O,
    output logic                   DQ_OE,
    input  wire logic [DATA_W-1:0] DQ_I,
    input  wire logic              BUSY_N
);
    // ==========================================================
    // State
    // ==========================================================
    dpsb_state_t         st_r, st_nxt;
    logic                wr_r, wr_nxt;
    logic                claim_r, claim_nxt;
    logic                tok_r, tok_nxt;
    logic [ADDR_W-1:0]   addr_r, addr_nxt;
    logic [DATA_W-1:0]   wd_r, wd_nxt;
    logic [DPSB_IDX_W-1:0] init_idx_r, init_idx_nxt;
    logic                rsp_v_r, rsp_v_nxt;
    logic [DATA_W-1:0]   rsp_d_r, rsp_d_nxt;
    logic                gnt_r, gnt_nxt;
    logic                idone_r, idone_nxt;
    logic                cs_n_r, cs_n_nxt, ts_n_r, ts_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, dqoe_r, dqoe_nxt;
    logic                ready_r, ready_nxt;
    logic [NTOK-1:0]     pend_r, pend_nxt;
    logic                cyc_start, cyc_strobe, cyc_setup, cyc_done;

    // Token index decode, shared by addressing and request bookkeeping
    function automatic logic [DPSB_IDX_W-1:0] tok_idx(input logic [ADDR_W-1:0] a);
        tok_idx = a[DPSB_IDX_W-1:0];
    endfunction

    function automatic logic [ADDR_W-1:0] tok_addr(input logic [ADDR_W-1:0] a);
        tok_addr = {{(ADDR_W-DPSB_IDX_W){1'b0}}, tok_idx(a)};
    endfunction

    dpsb_cycle u_cycle (
        .clk         (MCLK),
        .rst         (SYS_RST),
        .start       (cyc_start),
        // One master flags contention for the whole word, so one flag input
        .busy_hold   (wr_r && !tok_r && !BUSY_N),
        .strobe      (cyc_strobe),
        .phase_setup (cyc_setup),
        .done        (cyc_done)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_comb begin
        st_nxt = st_r;
        wr_nxt = wr_r;
        claim_nxt = claim_r;
        tok_nxt = tok_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        init_idx_nxt = init_idx_r;
        rsp_v_nxt = 1'b0;
        rsp_d_nxt = rsp_d_r;
        gnt_nxt = gnt_r;
        idone_nxt = idone_r;
        pend_nxt = pend_r;
        cyc_start = 1'b0;
        case (st_r)
            DPSB_INIT: begin
                // Token state is unknown after power-up, so free each one
                wr_nxt = 1'b1;
                tok_nxt = 1'b1;
                claim_nxt = 1'b0;
                addr_nxt = ADDR_W'(init_idx_r);
                wd_nxt = {DATA_W{1'b1}};
                st_nxt = DPSB_SETUP;
            end
            DPSB_IDLE: begin
                if (REQ_VALID && idone_r) begin
                    tok_nxt   = REQ_TOKEN || REQ_OP[1];
                    claim_nxt = (REQ_OP == DPSB_OP_CLAIM);
                    wr_nxt    = (REQ_OP != DPSB_OP_READ);
                    addr_nxt  = (REQ_TOKEN || REQ_OP[1]) ? tok_addr(REQ_ADDR) : REQ_ADDR;
                    // Claim writes zero, release writes one; bit 0 carries it
                    wd_nxt    = REQ_OP[1] ? {DATA_W{REQ_OP[0]}} : REQ_WDATA;
                    st_nxt    = DPSB_SETUP;
                    // Zero already latched: rewriting it adds nothing, so retry by reading only
                    if (REQ_OP == DPSB_OP_CLAIM && pend_r[tok_idx(REQ_ADDR)]) begin
                        wr_nxt = 1'b0;
                    end
                    // A one written to a token withdraws any pending request
                    if ((REQ_TOKEN || REQ_OP[1]) && REQ_OP != DPSB_OP_READ && wd_nxt[0]) begin
                        pend_nxt[tok_idx(REQ_ADDR)] = 1'b0;
                    end
                end
            end
            DPSB_SETUP: begin
                cyc_start = 1'b1;
                st_nxt = DPSB_PULSE;
            end
            DPSB_PULSE: begin
                if (cyc_done) begin
                    if (!wr_r) begin
                        rsp_d_nxt = DQ_I;
                        gnt_nxt = tok_r && !DQ_I[0];
                        // A claim that reads one leaves its zero latched as a request
                        if (claim_r) begin
                            pend_nxt[tok_idx(addr_r)] = DQ_I[0];
                        end
                    end
                    st_nxt = DPSB_REC;
                end
            end
            DPSB_REC: begin
                // A claim that writes reads back after its write, never before
                if (claim_r && wr_r) begin
                    wr_nxt = 1'b0;
                    st_nxt = DPSB_SETUP;
                end else if (!idone_r) begin
                    init_idx_nxt = init_idx_r + 3'h1;
                    st_nxt = (init_idx_r == 3'(NTOK - 1)) ? DPSB_NEXT : DPSB_INIT;
                    idone_nxt = (init_idx_r == 3'(NTOK - 1));
                end else begin
                    rsp_v_nxt = 1'b1;
                    st_nxt = DPSB_NEXT;
                end
            end
            DPSB_NEXT: st_nxt = DPSB_IDLE;
            default:   st_nxt = DPSB_IDLE;
        endcase
        ready_nxt = (st_nxt == DPSB_IDLE) && idone_nxt;
    end

    // Pin drive: selects drop between cycles so each poll recaptures the flag
    always_comb begin
        cs_n_nxt = 1'b1;
        ts_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        dqoe_nxt = 1'b0;
        if (st_r == DPSB_PULSE && !cyc_done) begin
            cs_n_nxt = tok_r;
            ts_n_nxt = !tok_r;
            oe_n_nxt = wr_r;
            we_n_nxt = !(wr_r && cyc_strobe);
            dqoe_nxt = wr_r;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            st_r <= DPSB_INIT;
            wr_r <= 1'b0;
            claim_r <= 1'b0;
            tok_r <= 1'b0;
            addr_r <= '0;
            wd_r <= '0;
            init_idx_r <= '0;
            rsp_v_r <= 1'b0;
            rsp_d_r <= '0;
            gnt_r <= 1'b0;
            idone_r <= 1'b0;
            pend_r <= '0;
            ready_r <= 1'b0;
            cs_n_r <= 1'b1;
            ts_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            dqoe_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            wr_r <= wr_nxt;
            claim_r <= claim_nxt;
            tok_r <= tok_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            init_idx_r <= init_idx_nxt;
            rsp_v_r <= rsp_v_nxt;
            rsp_d_r <= rsp_d_nxt;
            gnt_r <= gnt_nxt;
            idone_r <= idone_nxt;
            pend_r <= pend_nxt;
            ready_r <= ready_nxt;
            cs_n_r <= cs_n_nxt;
            ts_n_r <= ts_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            dqoe_r <= dqoe_nxt;
        end
    end

    assign REQ_READY      = ready_r;
    assign RSP_VALID      = rsp_v_r;
    assign RSP_RDATA      = rsp_d_r;
    assign RSP_GRANTED    = gnt_r;
    assign INIT_DONE      = idone_r;
    assign ARRAY_SEL_N    = cs_n_r;
    assign TOKEN_SELECT_N = ts_n_r;
    assign OUT_DRIVE_N    = oe_n_r;
    assign WRITE_N        = we_n_r;
    assign ADDR           = addr_r;
    assign DQ_O           = wd_r;
    assign DQ_OE          = dqoe_r;

    // ==========================================================
    // Checks
    // ==========================================================
    a_no_read_first: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $fell(OUT_DRIVE_N) && !TOKEN_SELECT_N && claim_r |-> !wr_r)
        else $error("claim read before write");
    a_select_gap: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $rose(TOKEN_SELECT_N) |=> TOKEN_SELECT_N)
        else $error("token select not released between accesses");
    a_init_ones: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !idone_r && !WRITE_N |-> DQ_O[0] && !TOKEN_SELECT_N)
        else $error("init write not a one");
    a_tok_index: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !TOKEN_SELECT_N |-> ADDR[ADDR_W-1:DPSB_IDX_W] == '0)
        else $error("token address high bits set");
    a_one_select: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !(!TOKEN_SELECT_N && !ARRAY_SEL_N))
        else $error("both selects active");
    a_wr_busy: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $fell(WRITE_N) && !ARRAY_SEL_N |-> !$past(ARRAY_SEL_N) && $past(BUSY_N))
        else $error("write strobe without prior select or while flag low");
    a_setup_quiet: assert property (@(posedge MCLK) disable iff (SYS_RST)
        cyc_setup |-> WRITE_N)
        else $error("write strobe during setup");
    a_retry_reads: assert property (@(posedge MCLK) disable iff (SYS_RST)
        st_r == DPSB_IDLE && REQ_VALID && idone_r && REQ_OP == DPSB_OP_CLAIM && pend_r[tok_idx(REQ_ADDR)] |=> !wr_r)
        else $error("retried claim wrote again");
endmodule // dpsb_host

// >>> verilog/dpsb_pkg.sv
// Constants and types for the dual-port token host controller.
// Assumes one clock MCLK at 125 MHz and a synchronous active-high reset.
package dpsb_pkg;
    localparam int DPSB_ADDR_W     = 13;
    localparam int DPSB_DATA_W     = 9;
    localparam int DPSB_IDX_W      = 3;
    localparam int DPSB_NTOK       = 8;
    // Pin timing, in ns
    localparam int DPSB_T_SETUP_NS = 20;
    localparam int DPSB_T_PULSE_NS = 25;
    localparam int DPSB_T_REC_NS   = 15;
    localparam int DPSB_CLK_NS     = 8;
    localparam int DPSB_SETUP_CYC  = (DPSB_T_SETUP_NS + DPSB_CLK_NS - 1) / DPSB_CLK_NS;
    localparam int DPSB_PULSE_CYC  = (DPSB_T_PULSE_NS + DPSB_CLK_NS - 1) / DPSB_CLK_NS;
    localparam int DPSB_REC_CYC    = (DPSB_T_REC_NS + DPSB_CLK_NS - 1) / DPSB_CLK_NS;
    localparam logic [1:0] DPSB_OP_READ    = 2'h0;
    localparam logic [1:0] DPSB_OP_WRITE   = 2'h1;
    localparam logic [1:0] DPSB_OP_CLAIM   = 2'h2;
    localparam logic [1:0] DPSB_OP_RELEASE = 2'h3;
    typedef enum logic [2:0] {
        DPSB_IDLE  = 3'h0,
        DPSB_SETUP = 3'h1,
        DPSB_PULSE = 3'h3,
        DPSB_REC   = 3'h2,
        DPSB_NEXT  = 3'h6,
        DPSB_INIT  = 3'h7
    } dpsb_state_t;
endpackage
